/* File: armi_pkg.sv */
// armi_pkg: constants and types for the reclose mode and initiation block
// assumes a single 10 MHz system clock domain
package armi_pkg;
    localparam int unsigned CLK_HZ           = 10_000_000;
    localparam int unsigned MODE_DELAY_MS    = 100;
    localparam int unsigned MODE_DELAY_CYC   = (CLK_HZ / 1000) * MODE_DELAY_MS;
    localparam int unsigned TRIP_SLOTS       = 5;
    localparam logic        AUTO_RESET_VALUE = 1'b0;

    // mode source selection
    localparam logic [1:0]  SRC_COMMAND = 2'h0;
    localparam logic [1:0]  SRC_LEVEL   = 2'h1;
    localparam logic [1:0]  SRC_USER    = 2'h2;
    localparam logic [1:0]  SRC_PULSE   = 2'h3;

    // stage initiation setting codes
    localparam logic [1:0]  INIT_NONE   = 2'h0;
    localparam logic [1:0]  INIT_MAIN   = 2'h1;
    localparam logic [1:0]  INIT_SENS   = 2'h2;

    typedef enum logic [1:0] {
        ARMI_NON_AUTO,
        ARMI_AUTO,
        ARMI_LIVE_LINE
    } armi_mode_type;
endpackage : armi_pkg

/* File: armi_core.sv */
// armi_core: reclose operating mode selection, initiation qualification and
// instantaneous protection blocking
// assumes protection inputs are synchronous and selector/SCADA inputs are pins
//
// Overview of operation
// [R1] auto puts reclose in service; non-auto removes it and may block instantaneous protection
// [R2] live line keeps reclose out of service and never applies deselect or per-trip blocking
// [R3] command source takes auto or non-auto from the commanded mode cell
// [R4] level source selects auto while auto level input is high
// [R5] user source uses command cell when remote enable high, else level input
// [R6] pulse source toggles mode on each scada pulse falling edge, else level input
// [R7] live line force input overrides every other mode selection
// [R8] selector switch drives auto, remote enable and live line inputs per position
// [R9] auto, remote enable and live line inputs are delayed 100 ms
// [R10] moving to telecontrol keeps the previous mode until a scada pulse in pulse source, for one cycle only in user source
// [R11] each stage setting chooses main, sensitive or no reclose initiation
// [R12] external trip and start initiate only when external setting selects main
// [R13] initiation needs auto, no live line, shots left, trip command or coordination, lockout clear, in service
// [R14] relevant protection trip is routed to the trip command input
// [R15] per trip number, main and sensitive settings block instantaneous elements
// [R16] fault frequency setting blocks at one below lockout count
// [R17] lockout, manual close and non-auto blocks each have their own setting
// [R18] reclose in service output asserted only in auto mode
// [R19] after reset mode is non-auto and input delays restart
`timescale 1ns/1ps
module armi_core
    import armi_pkg::*;
#(
    parameter int unsigned STAGES    = 8,
    parameter int unsigned DELAY_CYC = MODE_DELAY_CYC,
    parameter int unsigned CNT_W     = 20
) (
    // clock and reset
    input  wire logic                 clk_sys_in,
    input  wire logic                 nrst_in,
    // mode selection
    input  wire logic [1:0]           mode_source_setting_in,
    input  wire logic                 command_auto_in,
    input  wire logic                 auto_level_input_in,
    input  wire logic                 remote_enable_in,
    input  wire logic                 live_line_force_input_in,
    // blocking settings
    input  wire logic                 deselect_block_setting_in,
    input  wire logic                 fault_frequency_block_setting_in,
    input  wire logic                 lockout_block_setting_in,
    input  wire logic                 manual_close_block_setting_in,
    input  wire logic [TRIP_SLOTS-1:0] per_trip_main_block_in,
    input  wire logic [TRIP_SLOTS-1:0] per_trip_sensitive_block_in,
    input  wire logic [2:0]           trip_number_in,
    // lockout status
    input  wire logic                 locked_out_in,
    input  wire logic                 manual_close_inhibit_in,
    input  wire logic                 ops_count_penultimate_in,
    input  wire logic                 fault_freq_penultimate_in,
    // initiation sources
    input  wire logic [STAGES*2-1:0]  stage_initiation_setting_in,
    input  wire logic [STAGES-1:0]    stage_operate_in,
    input  wire logic                 trip_command_in,
    input  wire logic [1:0]           external_init_setting_in,
    input  wire logic                 external_trip_initiate_in,
    input  wire logic                 external_start_initiate_in,
    // initiation qualifiers
    input  wire logic                 main_shots_reached_in,
    input  wire logic                 sensitive_shots_reached_in,
    input  wire logic                 seq_coord_enable_in,
    input  wire logic                 breaker_ops_lockout_flag_in,
    input  wire logic                 breaker_in_service_flag_in,
    // outputs
    output logic [1:0]                mode_out,
    output logic                      reclose_in_service_flag_out,
    output logic                      main_initiate_out,
    output logic                      sensitive_initiate_out,
    output logic                      block_main_inst_out,
    output logic                      block_sensitive_inst_out
);
    // synchronisers for pin inputs
    logic [2:0] sync1;
    logic [2:0] sync2;
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
        end else begin
            sync1 <= {live_line_force_input_in, remote_enable_in, auto_level_input_in};
            sync2 <= sync1;
        end
    end

    // 100 ms qualification delay per input: output follows after stable period
    logic [2:0] dly;
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_dly
            logic [CNT_W-1:0] cnt;
            always_ff @(posedge clk_sys_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    cnt     <= '0; // R19
                    dly[gi] <= 1'b0;
                end else if (sync2[gi] == dly[gi]) begin
                    cnt <= '0;
                end else if (cnt >= CNT_W'(DELAY_CYC - 1)) begin
                    cnt     <= '0;
                    dly[gi] <= sync2[gi]; // R9
                end else begin
                    cnt <= cnt + 1'b1;
                end
            end
        end
    endgenerate

    wire auto_d   = dly[0];
    wire remote_d = dly[1];
    wire live_d   = dly[2];

    // telecontrol rise, and scada pulse falling edge on the auto line while telecontrol is held
    logic remote_prev;
    logic auto_prev;
    logic auto_state;
    wire  remote_rise = ~remote_prev & remote_d;
    wire  pulse_fall  = auto_prev & ~auto_d & remote_prev & remote_d; // no toggle on a switch move

    // next stored auto state by source
    logic next_auto;
    always_comb begin
        next_auto = auto_state;
        case (mode_source_setting_in)
            SRC_COMMAND: next_auto = command_auto_in; // R3
            SRC_LEVEL:   next_auto = auto_d; // R4
            SRC_USER: begin
                if (remote_d) next_auto = remote_rise ? auto_state : command_auto_in; // R5 R10
                else          next_auto = auto_d; // R5
            end
            SRC_PULSE: begin
                if (!remote_d)       next_auto = auto_d; // R6
                else if (pulse_fall) next_auto = ~auto_state; // R6
                else                 next_auto = auto_state; // R10
            end
            default:     next_auto = auto_state;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            auto_state  <= AUTO_RESET_VALUE; // R19
            remote_prev <= 1'b0;
            auto_prev   <= 1'b0;
        end else begin
            auto_state  <= next_auto;
            remote_prev <= remote_d;
            auto_prev   <= auto_d;
        end
    end

    // operating mode decode
    wire in_live = live_d; // R7
    wire in_auto = auto_state & ~live_d;
    wire in_non  = ~auto_state & ~live_d;
    assign mode_out = in_live ? 2'(ARMI_LIVE_LINE) : (in_auto ? 2'(ARMI_AUTO) : 2'(ARMI_NON_AUTO));
    assign reclose_in_service_flag_out = in_auto; // R1 R2 R18

    // stage initiation requests
    logic [STAGES-1:0] st_main;
    logic [STAGES-1:0] st_sens;
    generate
        for (gi = 0; gi < STAGES; gi++) begin : g_stage
            wire [1:0] cfg = stage_initiation_setting_in[gi*2 +: 2];
            assign st_main[gi] = stage_operate_in[gi] & (cfg == INIT_MAIN); // R11
            assign st_sens[gi] = stage_operate_in[gi] & (cfg == INIT_SENS); // R11
        end
    endgenerate

    // trip based initiation only through the trip command input
    wire ext_main   = (external_init_setting_in == INIT_MAIN); // R12
    wire ext_trip   = ext_main & external_trip_initiate_in & trip_command_in; // R12 R14
    wire ext_start  = ext_main & external_start_initiate_in & seq_coord_enable_in; // R12 R13
    wire common_ok  = in_auto & ~live_d & ~breaker_ops_lockout_flag_in & breaker_in_service_flag_in; // R13
    wire main_req   = ext_trip | ext_start | (trip_command_in & (|st_main))
                    | (seq_coord_enable_in & (|st_main));
    wire sens_req   = (trip_command_in | seq_coord_enable_in) & (|st_sens);
    wire shots_ok   = ~main_shots_reached_in & ~sensitive_shots_reached_in; // R13

    // initiation outputs registered
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            main_initiate_out      <= 1'b0;
            sensitive_initiate_out <= 1'b0;
        end else begin
            main_initiate_out      <= common_ok & shots_ok & main_req; // R13
            sensitive_initiate_out <= common_ok & shots_ok & sens_req; // R13
        end
    end

    // instantaneous blocking terms
    wire       slot_ok   = (trip_number_in != 3'h0) && (trip_number_in <= 3'(TRIP_SLOTS));
    wire [2:0] slot      = slot_ok ? 3'(trip_number_in - 3'h1) : 3'h0;
    wire       trip_main = slot_ok & per_trip_main_block_in[slot]; // R15
    wire       trip_sens = slot_ok & per_trip_sensitive_block_in[slot]; // R15
    wire       ff_blk    = fault_frequency_block_setting_in
                         & (ops_count_penultimate_in | fault_freq_penultimate_in); // R16
    wire       lock_blk  = (lockout_block_setting_in & locked_out_in)
                         | (manual_close_block_setting_in & manual_close_inhibit_in)
                         | (deselect_block_setting_in & in_non); // R1 R2 R17
    wire       common_blk = ff_blk | lock_blk;

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            block_main_inst_out      <= 1'b0;
            block_sensitive_inst_out <= 1'b0;
        end else begin
            block_main_inst_out      <= common_blk | (in_auto & trip_main); // R15
            block_sensitive_inst_out <= common_blk | (in_auto & trip_sens); // R15
        end
    end

    // checks
    property p_live_override;
        @(posedge clk_sys_in) disable iff (!nrst_in) live_d |-> mode_out == 2'(ARMI_LIVE_LINE);
    endproperty
    a_live_override: assert property (p_live_override) else $error("live line not forced"); // R7
    property p_service_auto;
        @(posedge clk_sys_in) disable iff (!nrst_in)
            reclose_in_service_flag_out == (mode_out == 2'(ARMI_AUTO));
    endproperty
    a_service_auto: assert property (p_service_auto) else $error("in service mismatch"); // R18
    property p_live_no_block;
        @(posedge clk_sys_in) disable iff (!nrst_in)
            (live_d && $past(live_d) && !ff_blk && !locked_out_in && !manual_close_inhibit_in)
            |=> !block_main_inst_out || ff_blk || locked_out_in || manual_close_inhibit_in;
    endproperty
    a_live_no_block: assert property (p_live_no_block) else $error("live line blocked protection"); // R2
    property p_init_needs_auto;
        @(posedge clk_sys_in) disable iff (!nrst_in)
            main_initiate_out |-> $past(in_auto) && !$past(breaker_ops_lockout_flag_in);
    endproperty
    a_init_needs_auto: assert property (p_init_needs_auto) else $error("initiation without auto"); // R13
    property p_command_src;
        @(posedge clk_sys_in) disable iff (!nrst_in)
            mode_source_setting_in == SRC_COMMAND && $past(nrst_in) |=> auto_state == $past(command_auto_in);
    endproperty
    a_command_src: assert property (p_command_src) else $error("command source ignored"); // R3
    property p_level_src;
        @(posedge clk_sys_in) disable iff (!nrst_in)
            mode_source_setting_in == SRC_LEVEL && $past(nrst_in) |=> auto_state == $past(auto_d);
    endproperty
    a_level_src: assert property (p_level_src) else $error("level source ignored"); // R4
    sequence s_fall;
        pulse_fall && mode_source_setting_in == SRC_PULSE;
    endsequence
    property p_pulse_toggle;
        @(posedge clk_sys_in) disable iff (!nrst_in) s_fall |=> auto_state != $past(auto_state);
    endproperty
    a_pulse_toggle: assert property (p_pulse_toggle) else $error("pulse did not toggle"); // R6
    property p_delay;
        @(posedge clk_sys_in) disable iff (!nrst_in)
            $rose(dly[2]) |-> $past(sync2[2]) && $past(g_dly[2].cnt) == CNT_W'(DELAY_CYC - 1);
    endproperty
    a_delay: assert property (p_delay) else $error("delay released early"); // R9
endmodule : armi_core

/* File: armi_field.sv */
// armi_field: selector switch, scada pulse and protection stage model
// assumes the bench clock; pins change just after each rising edge
`timescale 1ns/1ps
module armi_field (
    // clock
    input  wire logic       clk_sys_in,
    // position 0 non-auto, 1 telecontrol, 2 auto, 3 live line
    input  wire logic [1:0] position_in,
    input  wire logic       pulse_in,
    input  wire logic [7:0] stage_trip_in,
    input  wire logic       ext_trip_in,
    // pins towards the block
    output logic            auto_level_out,
    output logic            remote_enable_out,
    output logic            live_line_out,
    output logic [7:0]      stage_operate_out,
    output logic            trip_command_out,
    output logic            ext_trip_out
);
    // switch contacts and trip routing; the scada pulse rides the auto line in telecontrol
    always_ff @(posedge clk_sys_in) begin
        auto_level_out    <= (position_in == 2'h2) | ((position_in == 2'h1) & pulse_in);
        remote_enable_out <= (position_in == 2'h1);
        live_line_out     <= (position_in == 2'h3);
        stage_operate_out <= stage_trip_in;
        ext_trip_out      <= ext_trip_in;
        trip_command_out  <= (|stage_trip_in) | ext_trip_in;
    end
endmodule : armi_field

/* File: armi_core_tb_top.sv */
// armi_core_tb_top: directed scenarios for mode, initiation and blocking
// assumes armi_core with a short pin delay and the armi_field model
`timescale 1ns/1ps
module armi_core_tb_top import armi_pkg::*;;
    localparam int unsigned DLY = 10;
    // bench stimulus
    logic        clk_sys_in = 1'b0, nrst_in = 1'b0, cmd = 1'b0, pls = 1'b0;
    logic        ext_t = 1'b0, ext_s = 1'b0;
    logic [1:0]  src = SRC_COMMAND, pos = 2'h0, ext_set = INIT_NONE;
    logic [3:0]  blk_set = 4'h0, lck = 4'h0;
    logic [4:0]  pt_main = 5'h00, pt_sens = 5'h00, qual = 5'h05;
    logic [2:0]  trip_n = 3'h0;
    logic [15:0] stage_set = 16'h0000;
    logic [7:0]  trips = 8'h00, stage_op;
    logic        auto_lv, rem_en, live, trip_cmd, ext_trip;
    logic        in_svc, m_init, s_init, b_main, b_sens;
    logic [1:0]  mode;
    int          num_errors = 0, checks = 0;
    // clock
    initial begin
        forever #50 clk_sys_in = ~clk_sys_in;
    end
    // partner and design
    armi_field u_armi_field (.clk_sys_in(clk_sys_in), .position_in(pos), .pulse_in(pls),
        .stage_trip_in(trips), .ext_trip_in(ext_t), .auto_level_out(auto_lv), .remote_enable_out(rem_en),
        .live_line_out(live), .stage_operate_out(stage_op), .trip_command_out(trip_cmd), .ext_trip_out(ext_trip));
    armi_core #(.DELAY_CYC(DLY)) u_armi_core (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
        .mode_source_setting_in(src), .command_auto_in(cmd), .auto_level_input_in(auto_lv),
        .remote_enable_in(rem_en), .live_line_force_input_in(live), .deselect_block_setting_in(blk_set[0]),
        .fault_frequency_block_setting_in(blk_set[1]), .lockout_block_setting_in(blk_set[2]),
        .manual_close_block_setting_in(blk_set[3]), .per_trip_main_block_in(pt_main),
        .per_trip_sensitive_block_in(pt_sens), .trip_number_in(trip_n), .locked_out_in(lck[0]),
        .manual_close_inhibit_in(lck[1]), .ops_count_penultimate_in(lck[2]), .fault_freq_penultimate_in(lck[3]),
        .stage_initiation_setting_in(stage_set), .stage_operate_in(stage_op), .trip_command_in(trip_cmd),
        .external_init_setting_in(ext_set), .external_trip_initiate_in(ext_trip),
        .external_start_initiate_in(ext_s), .main_shots_reached_in(qual[4]), .sensitive_shots_reached_in(qual[3]),
        .seq_coord_enable_in(qual[2]), .breaker_ops_lockout_flag_in(qual[1]), .breaker_in_service_flag_in(qual[0]),
        .mode_out(mode), .reclose_in_service_flag_out(in_svc), .main_initiate_out(m_init),
        .sensitive_initiate_out(s_init), .block_main_inst_out(b_main), .block_sensitive_inst_out(b_sens));
    // shared compare, settle and bounded mode wait
    task automatic chk(input logic [1:0] got, input logic [1:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: got %0d expected %0d", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
    endtask : cyc
    task automatic wait_mode(input logic [1:0] exp);
        int n;
        n = 0;
        while (mode !== exp && n < 4 * DLY) begin
            @(negedge clk_sys_in);
            n++;
        end
        chk(mode, exp);
    endtask : wait_mode
    // command, live line, level and user selection
    task automatic t_modes;
        chk(mode, ARMI_NON_AUTO);
        chk({1'b0, in_svc}, 2'h0);
        @(posedge clk_sys_in);
        cmd <= 1'b1;
        wait_mode(ARMI_AUTO);
        chk({1'b0, in_svc}, 2'h1);
        @(posedge clk_sys_in);
        pos <= 2'h3;
        wait_mode(ARMI_LIVE_LINE);
        chk({1'b0, in_svc}, 2'h0);
        @(posedge clk_sys_in);
        src <= SRC_LEVEL;
        pos <= 2'h2;
        cyc(DLY / 2);
        chk(mode, ARMI_LIVE_LINE);
        wait_mode(ARMI_AUTO);
        @(posedge clk_sys_in);
        pos <= 2'h3;
        cyc(DLY / 2);
        @(posedge clk_sys_in);
        pos <= 2'h2;
        cyc(2 * DLY);
        chk(mode, ARMI_AUTO);
        @(posedge clk_sys_in);
        pos <= 2'h0;
        wait_mode(ARMI_NON_AUTO);
        @(posedge clk_sys_in);
        src <= SRC_USER;
        pos <= 2'h1;
        wait_mode(ARMI_AUTO);
        @(posedge clk_sys_in);
        cmd <= 1'b0;
        wait_mode(ARMI_NON_AUTO);
        @(posedge clk_sys_in);
        pos <= 2'h2;
        wait_mode(ARMI_AUTO);
        @(posedge clk_sys_in);
        pos <= 2'h0;
        wait_mode(ARMI_NON_AUTO);
    endtask : t_modes
    // retention on moving to telecontrol, then scada pulses toggling the mode
    task automatic t_pulse;
        @(posedge clk_sys_in);
        src <= SRC_PULSE;
        pos <= 2'h2;
        wait_mode(ARMI_AUTO);
        @(posedge clk_sys_in);
        pos <= 2'h1;
        cyc(3 * DLY);
        chk(mode, ARMI_AUTO);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_sys_in);
            pls <= 1'b1;
            cyc(2 * DLY);
            chk(mode, (k == 0) ? ARMI_AUTO : ARMI_NON_AUTO);
            @(posedge clk_sys_in);
            pls <= 1'b0;
            wait_mode((k == 0) ? ARMI_NON_AUTO : ARMI_AUTO);
        end
        @(posedge clk_sys_in);
        pos <= 2'h0;
        wait_mode(ARMI_NON_AUTO);
    endtask : t_pulse
    // stage and external initiation with each qualifier broken
    task automatic t_init;
        @(posedge clk_sys_in);
        src <= SRC_COMMAND;
        cmd <= 1'b1;
        stage_set <= 16'h0001;
        trips <= 8'h01;
        wait_mode(ARMI_AUTO);
        cyc(3);
        chk({1'b0, m_init}, 2'h1);
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_sys_in);
            qual <= (i == 2) ? 5'h05 : 5'h05 ^ (5'h01 << i);
            cyc(3);
            chk({1'b0, m_init}, (i == 2) ? 2'h1 : 2'h0);
        end
        @(posedge clk_sys_in);
        qual <= 5'h05;
        stage_set <= 16'h0000;
        cyc(3);
        chk({1'b0, m_init}, 2'h0);
        @(posedge clk_sys_in);
        stage_set <= 16'h0008;
        trips <= 8'h02;
        cyc(3);
        chk({1'b0, s_init}, 2'h1);
        @(posedge clk_sys_in);
        trips <= 8'h00;
        ext_t <= 1'b1;
        ext_set <= INIT_MAIN;
        cyc(3);
        chk({1'b0, m_init}, 2'h1);
        @(posedge clk_sys_in);
        ext_set <= INIT_NONE;
        cyc(3);
        chk({1'b0, m_init}, 2'h0);
        @(posedge clk_sys_in);
        ext_t <= 1'b0;
        ext_s <= 1'b1;
        ext_set <= INIT_MAIN;
        cyc(3);
        chk({1'b0, m_init}, 2'h1);
        @(posedge clk_sys_in);
        qual <= 5'h01;
        cyc(3);
        chk({1'b0, m_init}, 2'h0);
        @(posedge clk_sys_in);
        qual <= 5'h05;
        cmd <= 1'b0;
        wait_mode(ARMI_NON_AUTO);
        cyc(3);
        chk({1'b0, m_init}, 2'h0);
        @(posedge clk_sys_in);
        ext_s <= 1'b0;
    endtask : t_init
    // per-trip, lockout and deselect blocking
    task automatic t_block;
        logic [7:0] tbl [4] = '{8'h24, 8'h28, 8'h41, 8'h82};
        @(posedge clk_sys_in);
        cmd <= 1'b1;
        wait_mode(ARMI_AUTO);
        for (int n = 1; n <= 5; n++) begin
            @(posedge clk_sys_in);
            trip_n <= 3'(n);
            pt_main <= 5'h01 << (n - 1);
            pt_sens <= ~(5'h01 << (n - 1));
            cyc(3);
            chk({b_main, b_sens}, 2'h2);
        end
        @(posedge clk_sys_in);
        trip_n <= 3'h0;
        cyc(3);
        chk({b_main, b_sens}, 2'h0);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys_in);
            blk_set <= tbl[k][7:4];
            cyc(3);
            chk({1'b0, b_main}, 2'h0);
            @(posedge clk_sys_in);
            lck <= tbl[k][3:0];
            cyc(3);
            chk({1'b0, b_main}, 2'h1);
            @(posedge clk_sys_in);
            lck <= 4'h0;
        end
        @(posedge clk_sys_in);
        blk_set <= 4'h1;
        cmd <= 1'b0;
        wait_mode(ARMI_NON_AUTO);
        cyc(3);
        chk({1'b0, b_main}, 2'h1);
        @(posedge clk_sys_in);
        pos <= 2'h3;
        wait_mode(ARMI_LIVE_LINE);
        cyc(3);
        chk({1'b0, b_main}, 2'h0);
    endtask : t_block
    // mid-run reset: mode returns to non-auto and the pin delays start again
    task automatic t_reset;
        @(posedge clk_sys_in);
        pos <= 2'h0;
        cmd <= 1'b1;
        wait_mode(ARMI_AUTO);
        @(posedge clk_sys_in);
        pos <= 2'h3;
        cyc(DLY / 2);
        @(posedge clk_sys_in);
        nrst_in <= 1'b0;
        @(negedge clk_sys_in);
        chk(mode, ARMI_NON_AUTO);
        chk({m_init, b_main}, 2'h0);
        @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        cyc(DLY / 2);
        chk(mode, ARMI_AUTO);
        wait_mode(ARMI_LIVE_LINE);
    endtask : t_reset
    // verdict
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop
    // watchdog
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        num_errors++;
        report_and_stop();
    end
    // main sequence
    initial begin
        repeat (6) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        @(negedge clk_sys_in);
        t_modes();
        t_pulse();
        t_init();
        t_block();
        t_reset();
        report_and_stop();
    end
endmodule : armi_core_tb_top
